// ### hw/fltseq_pkg.sv
package fltseq_pkg;
   // ***************
   // timing
   // ***************
   localparam int CLK_PERIOD_NS   = 20;
   localparam int US_NS           = 1000;
   localparam int PS_PER_NS       = 1000;
   localparam int CYC_PER_US      = US_NS / CLK_PERIOD_NS;
   localparam int CLK_PERIOD_PS   = CLK_PERIOD_NS * PS_PER_NS;
   localparam int FINE_STEP_PS    = 31250;
   localparam int INTEG_DELAY_NS  = 9000;
   localparam int INTEG_DELAY_CYC =
      (INTEG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ***************
   // register indices (byte address = 4 * index)
   // ***************
   localparam logic [6:0] IDX_LED_SEL = 7'h14;
   localparam logic [6:0] IDX_CONN_A  = 7'h30;
   localparam logic [6:0] IDX_PCNT_A  = 7'h31;
   localparam logic [6:0] IDX_CONN_B  = 7'h35;
   localparam logic [6:0] IDX_PCNT_B  = 7'h36;
   localparam logic [6:0] IDX_PER_HI  = 7'h37;
   localparam logic [6:0] IDX_INTEG_A = 7'h39;
   localparam logic [6:0] IDX_INTEG_B = 7'h3B;
   localparam logic [6:0] IDX_FLED_A  = 7'h3E;
   localparam logic [6:0] IDX_FLED_B  = 7'h3F;
   localparam logic [6:0] IDX_MATH    = 7'h58;
   localparam logic [6:0] IDX_PREC_B  = 7'h59;
   localparam logic [6:0] IDX_FIRE    = 7'h5A;
   localparam logic [6:0] IDX_PREC_A  = 7'h5E;
   localparam logic [6:0] IDX_CTRL    = 7'h70;
   localparam logic [6:0] IDX_STATUS  = 7'h71;
   localparam logic [6:0] IDX_RESULT  = 7'h72;
   localparam int NREG = 14;
   localparam logic [6:0] IDX_TABLE [NREG] = '{
      IDX_LED_SEL, IDX_CONN_A, IDX_PCNT_A, IDX_CONN_B, IDX_PCNT_B,
      IDX_PER_HI, IDX_INTEG_A, IDX_INTEG_B, IDX_FLED_A, IDX_FLED_B,
      IDX_MATH, IDX_PREC_B, IDX_FIRE, IDX_PREC_A};
   // storage positions, per slot where the slot has its own register
   localparam int P_LED_SEL = 0;
   localparam int P_PER_HI  = 5;
   localparam int P_MATH    = 10;
   localparam int P_FIRE    = 12;
   localparam int P_CONN [2]  = '{1, 3};
   localparam int P_PCNT [2]  = '{2, 4};
   localparam int P_INTEG [2] = '{6, 7};
   localparam int P_FLED [2]  = '{8, 9};
   localparam int P_PREC [2]  = '{13, 11};
   localparam logic [15:0] REG_RST = 16'h0000;
   // ***************
   // field positions
   // ***************
   localparam int LEDSEL_LSB [2] = '{0, 2};
   localparam int PERHI_LSB [2]  = '{0, 8};
   localparam int FIRE_LSB [2]   = '{8, 12};
   localparam int MATH12_LSB [2] = '{1, 5};
   localparam int MATH34_LSB [2] = '{8, 10};
   localparam int PRECON_LSB = 8;
   localparam int FEN_LSB    = 13;
   localparam int PERLO_LSB  = 0;
   localparam int COUNT_LSB  = 8;
   localparam int CONN_LSB   = 8;
   localparam int DUMP_LSB   = 0;
   localparam int IWID_LSB   = 11;
   localparam int IOFF_LSB   = 0;
   localparam int FLW_LSB    = 8;
   localparam int FLF_LSB    = 0;
   localparam int FLC_LSB    = 14;
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_SLOT_BIT  = 1;
   // ***************
   // codes
   // ***************
   localparam logic [1:0] FLOAT_EN_ON   = 2'h3;
   localparam logic [1:0] LED_SEL_FLOAT = 2'h0;
   localparam logic [1:0] MATH_SUB_ADD  = 2'h2;
   localparam logic [1:0] MATH_ADD_SUB  = 2'h1;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;
   typedef enum logic [2:0] {
      S_IDLE, S_CHECK, S_PRECON, S_FLOAT, S_CONNECT
   } seq_state_t;
endpackage

// ### hw/pulse_accumulator.sv
module pulse_accumulator #(
   parameter int ACC_W = 24,
   parameter int SMP_W = 14
) (
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic                    clear,
   input  wire logic                    add_en,
   input  wire logic                    sub_en,
   input  wire logic signed [SMP_W-1:0] sample,
   output logic signed      [ACC_W-1:0] acc
);
   // ***************
   // signed running sum over one pulse train
   // ***************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         acc <= '0;
      end else if (clear) begin
         acc <= '0;
      end else if (add_en) begin
         acc <= acc + ACC_W'(sample);
      end else if (sub_en) begin
         acc <= acc - ACC_W'(sample);
      end
   end
endmodule // pulse_accumulator

// ### hw/float_led_pulse_sequencer.sv
// Function
// R1: float LED code picks none or LED 1-3
// R2: float only with LED select 0, enable 3
// R3: precondition time precedes first float interval
// R4: float period is 2 high plus 8 low bits
// R5: later pulses float for the float period
// R6: first float = dump + connect - precondition
// R7: software sets first float equal second float
// R8: connect width sets charge dump time
// R9: software sets integration width connect plus one
// R10: integrator start in 31.25 ns steps plus delay
// R11: software sets even pulse count, minimum two
// R12: float LED pulse width in microseconds
// R13: float LED first pulse time
// R14: active-low fire mask per group position
// R15: group pattern repeats, one result per train
// R16: negative integration phase sits on charge dump
// R17: sign codes select add and subtract positions
// R18: ambient code subtracts first, adds second
// R19: pulse is float then connect, counter timed
//
// The implementer's own choice: the AXI4-Lite slave port.
module float_led_pulse_sequencer
   import fltseq_pkg::*;
#(
   parameter int ACC_W = 24,
   parameter int SMP_W = 14
) (
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic [8:0]              awaddr,
   input  wire logic                    awvalid,
   output logic                         awready,
   input  wire logic [31:0]             wdata,
   input  wire logic [3:0]              wstrb,
   input  wire logic                    wvalid,
   output logic                         wready,
   output logic [1:0]                   bresp,
   output logic                         bvalid,
   input  wire logic                    bready,
   input  wire logic [8:0]              araddr,
   input  wire logic                    arvalid,
   output logic                         arready,
   output logic [31:0]                  rdata,
   output logic [1:0]                   rresp,
   output logic                         rvalid,
   input  wire logic                    rready,
   input  wire logic signed [SMP_W-1:0] adc_sample,
   output logic [2:0]                   led_drive,
   output logic                         pd_connect,
   output logic                         integ_active,
   output logic                         integ_negative,
   output logic                         pulse_add,
   output logic                         pulse_sub,
   output logic                         result_valid,
   output logic signed [ACC_W-1:0]      result_data,
   output logic                         busy
);
   // ***************
   // register bus
   // ***************
   logic [15:0]       regs_r [NREG];
   logic              aw_got_r;
   logic              w_got_r;
   logic [6:0]        aw_idx_r;
   logic [31:0]       wdata_r;
   logic [3:0]        wstrb_r;
   logic              bvalid_r;
   logic [1:0]        bresp_r;
   logic              rvalid_r;
   logic [31:0]       rdata_r;
   logic [1:0]        rresp_r;
   logic              wr_fire;
   int                wr_slot;
   int                rd_slot;
   logic              wr_ok;
   logic              rd_ok;
   logic [31:0]       rd_data;
   logic              start_req;
   logic [31:0]       status;
   seq_state_t        state_r;
   logic              slot_r;
   logic              refused_r;
   logic [7:0]        pidx_r;
   logic signed [ACC_W-1:0] acc;

   function automatic int find_slot(input logic [6:0] idx);
      int k;
      find_slot = -1;
      for (k = 0; k < NREG; k++) begin
         if (IDX_TABLE[k] == idx) begin
            find_slot = k;
         end
      end
   endfunction

   assign awready = !aw_got_r;
   assign wready  = !w_got_r;
   assign bvalid  = bvalid_r;
   assign bresp   = bresp_r;
   assign arready = !rvalid_r;
   assign rvalid  = rvalid_r;
   assign rdata   = rdata_r;
   assign rresp   = rresp_r;
   assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
   assign wr_slot = find_slot(aw_idx_r);
   assign wr_ok   = (wr_slot >= 0) || (aw_idx_r == IDX_CTRL);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         aw_got_r <= 1'b0;
         w_got_r  <= 1'b0;
         aw_idx_r <= '0;
         wdata_r  <= '0;
         wstrb_r  <= '0;
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_got_r <= 1'b1;
            aw_idx_r <= awaddr[8:2];
         end
         if (wvalid && wready) begin
            w_got_r <= 1'b1;
            wdata_r <= wdata;
            wstrb_r <= wstrb;
         end
         if (wr_fire) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_r && bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // 16-bit registers: only the two low byte lanes are stored
   for (genvar g = 0; g < NREG; g++) begin : g_reg
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            regs_r[g] <= REG_RST;
         end else if (wr_fire && wr_slot == g) begin
            if (wstrb_r[0]) begin
               regs_r[g][7:0] <= wdata_r[7:0];
            end
            if (wstrb_r[1]) begin
               regs_r[g][15:8] <= wdata_r[15:8];
            end
         end
      end
   end

   assign start_req = wr_fire && aw_idx_r == IDX_CTRL && wstrb_r[0]
                      && wdata_r[CTRL_START_BIT];
   assign status = {14'h0000, pidx_r, 4'h0, refused_r, slot_r,
                    state_r, busy};

   always_comb begin
      rd_slot = find_slot(araddr[8:2]);
      rd_data = '0;
      rd_ok   = 1'b1;
      if (rd_slot >= 0) begin
         rd_data = {16'h0000, regs_r[rd_slot[3:0]]};
      end else if (araddr[8:2] == IDX_STATUS) begin
         rd_data = status;
      end else if (araddr[8:2] == IDX_RESULT) begin
         rd_data = 32'(result_data);
      end else if (araddr[8:2] == IDX_CTRL) begin
         rd_data[CTRL_SLOT_BIT] = slot_r;
      end else begin
         rd_ok = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rvalid_r <= 1'b0;
         rdata_r  <= '0;
         rresp_r  <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_data;
         rresp_r  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // ***************
   // active slot fields
   // ***************
   logic [1:0]  ledsel, fen, flc, m12, m34, code;
   logic [4:0]  precon, conn, iw, flw;
   logic [7:0]  per_lo, count, dump, flf;
   logic [1:0]  per_hi;
   logic [9:0]  period;
   logic [10:0] ioff;
   logic [3:0]  fire;
   logic [1:0]  pos;
   logic        float_ok, fire_en, add_now, sub_now, last_end;
   logic [15:0] cyc_r;
   int          f_us, float_end, pulse_end, precon_end;
   int          led_beg, led_end, int_beg, int_end;

   assign ledsel = regs_r[P_LED_SEL][LEDSEL_LSB[slot_r] +: 2];
   assign precon = regs_r[P_PREC[slot_r]][PRECON_LSB +: 5];
   assign fen    = regs_r[P_PREC[slot_r]][FEN_LSB +: 2];
   assign per_lo = regs_r[P_PCNT[slot_r]][PERLO_LSB +: 8];
   assign count  = regs_r[P_PCNT[slot_r]][COUNT_LSB +: 8];
   assign per_hi = regs_r[P_PER_HI][PERHI_LSB[slot_r] +: 2];
   assign period = {per_hi, per_lo};  // [R4]
   assign conn   = regs_r[P_CONN[slot_r]][CONN_LSB +: 5];
   assign dump   = regs_r[P_CONN[slot_r]][DUMP_LSB +: 8];
   assign iw     = regs_r[P_INTEG[slot_r]][IWID_LSB +: 5];
   assign ioff   = regs_r[P_INTEG[slot_r]][IOFF_LSB +: 11];
   assign flc    = regs_r[P_FLED[slot_r]][FLC_LSB +: 2];
   assign flw    = regs_r[P_FLED[slot_r]][FLW_LSB +: 5];
   assign flf    = regs_r[P_FLED[slot_r]][FLF_LSB +: 8];
   assign fire   = regs_r[P_FIRE][FIRE_LSB[slot_r] +: 4];
   assign m12    = regs_r[P_MATH][MATH12_LSB[slot_r] +: 2];
   assign m34    = regs_r[P_MATH][MATH34_LSB[slot_r] +: 2];
   assign float_ok = ledsel == LED_SEL_FLOAT && fen == FLOAT_EN_ON; // [R2]

   // ***************
   // pulse timeline in clock cycles
   // ***************
   always_comb begin
      precon_end = int'(precon) * CYC_PER_US;  // [R3]
      if (pidx_r == 8'h00) begin
         f_us = int'(dump) + int'(conn) - int'(precon);  // [R6]
         if (f_us < 1) begin
            f_us = 1;
         end
      end else begin
         f_us = int'(period);  // [R5]
      end
      float_end = f_us * CYC_PER_US;
      pulse_end = float_end + int'(conn) * CYC_PER_US;  // [R8]
      led_beg = (int'(flf) - int'(precon)) * CYC_PER_US;  // [R13]
      if (led_beg < 0) begin
         led_beg = 0;
      end
      led_end = led_beg + int'(flw) * CYC_PER_US;  // [R12]
      int_beg = (int'(ioff) * FINE_STEP_PS + CLK_PERIOD_PS - 1)
                / CLK_PERIOD_PS + INTEG_DELAY_CYC - precon_end; // [R10]
      if (int_beg < 0) begin
         int_beg = 0;
      end
      int_end = int_beg + int'(iw) * CYC_PER_US;
   end

   // group position repeats every four pulses
   assign pos     = pidx_r[1:0];  // [R15]
   assign fire_en = !fire[pos];  // [R14]
   assign code    = pos[1] ? m34 : m12;
   assign add_now = (code == MATH_SUB_ADD && pos[0])
                    || (code == MATH_ADD_SUB && !pos[0]);  // [R17] [R18]
   assign sub_now = (code == MATH_SUB_ADD && !pos[0])
                    || (code == MATH_ADD_SUB && pos[0]);  // [R17] [R18]
   // a count of zero still runs one pulse
   assign last_end = state_r == S_CONNECT && int'(cyc_r) >= pulse_end - 1
                     && int'(pidx_r) + 1 >= int'(count);  // [R11]

   // ***************
   // sequencer
   // ***************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r   <= S_IDLE;
         slot_r    <= 1'b0;
         refused_r <= 1'b0;
         pidx_r    <= '0;
         cyc_r     <= '0;
      end else begin
         case (state_r)
            S_IDLE: begin
               if (start_req) begin
                  slot_r  <= wdata_r[CTRL_SLOT_BIT];
                  state_r <= S_CHECK;
               end
            end
            S_CHECK: begin
               pidx_r    <= '0;
               cyc_r     <= '0;
               refused_r <= !float_ok;
               state_r   <= float_ok ? S_PRECON : S_IDLE;  // [R2]
            end
            S_PRECON: begin
               if (int'(cyc_r) + 1 >= precon_end) begin  // [R3]
                  cyc_r   <= '0;
                  state_r <= S_FLOAT;
               end else begin
                  cyc_r <= cyc_r + 16'h0001;
               end
            end
            S_FLOAT: begin
               cyc_r <= cyc_r + 16'h0001;
               if (int'(cyc_r) + 1 >= float_end) begin  // [R19]
                  state_r <= S_CONNECT;
               end
            end
            S_CONNECT: begin
               if (int'(cyc_r) + 1 >= pulse_end) begin  // [R19]
                  cyc_r   <= '0;
                  pidx_r  <= pidx_r + 8'h01;
                  state_r <= last_end ? S_IDLE : S_FLOAT;
               end else begin
                  cyc_r <= cyc_r + 16'h0001;
               end
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end

   // ***************
   // drive outputs
   // ***************
   logic in_pulse;
   logic in_integ;
   logic led_on;
   assign in_pulse = state_r == S_FLOAT || state_r == S_CONNECT;
   assign in_integ = in_pulse && int'(cyc_r) >= int_beg
                     && int'(cyc_r) < int_end;
   assign led_on = state_r == S_FLOAT && fire_en && flc != 2'h0
                   && int'(cyc_r) >= led_beg && int'(cyc_r) < led_end;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         led_drive      <= 3'h0;
         pd_connect     <= 1'b0;
         integ_active   <= 1'b0;
         integ_negative <= 1'b0;
         pulse_add      <= 1'b0;
         pulse_sub      <= 1'b0;
         busy           <= 1'b0;
      end else begin
         led_drive <= led_on ? 3'(3'h1 << (flc - 2'h1)) : 3'h0; // [R1]
         pd_connect     <= state_r == S_CONNECT;  // [R8]
         integ_active   <= in_integ;
         integ_negative <= in_integ && state_r == S_CONNECT; // [R16]
         pulse_add      <= in_pulse && add_now;
         pulse_sub      <= in_pulse && sub_now;
         busy           <= state_r != S_IDLE;
      end
   end

   logic pulse_done;
   logic last_d_r;
   assign pulse_done = state_r == S_CONNECT
                       && int'(cyc_r) + 1 >= pulse_end;

   pulse_accumulator #(
      .ACC_W (ACC_W),
      .SMP_W (SMP_W)
   ) u_acc (
      .clk    (clk),
      .rst_n  (rst_n),
      .clear  (state_r == S_CHECK),
      .add_en (pulse_done && add_now),
      .sub_en (pulse_done && sub_now),
      .sample (adc_sample),
      .acc    (acc)
   );

   // one result per train, after the last pulse
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         last_d_r     <= 1'b0;
         result_valid <= 1'b0;
         result_data  <= '0;
      end else begin
         last_d_r     <= last_end;
         result_valid <= last_d_r;  // [R15]
         if (last_d_r) begin
            result_data <= acc;
         end
      end
   end

   // ***************
   // checks
   // ***************
   a_led_code_map: assert property (@(posedge clk) disable iff (!rst_n)
      led_drive != 3'h0 |-> $onehot(led_drive) && $past(flc) != 2'h0)
      else $error("led drive not one-hot or code zero"); // [R1]
   a_float_refuse: assert property (@(posedge clk) disable iff (!rst_n)
      state_r == S_CHECK && !float_ok |=> state_r == S_IDLE && refused_r)
      else $error("start not refused outside float mode"); // [R2]
   a_precon_len: assert property (@(posedge clk) disable iff (!rst_n)
      state_r == S_PRECON && cyc_r == 16'h0000 && precon == 5'h06
      |-> ##299 state_r == S_PRECON ##1 state_r == S_FLOAT)
      else $error("precondition of 6 us not 300 cycles"); // [R3]
   a_later_float: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(state_r == S_CONNECT) && pidx_r != 8'h00
      |-> int'(cyc_r) == int'({per_hi, per_lo}) * CYC_PER_US)
      else $error("later float not equal to period"); // [R4] [R5]
   a_first_float: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(state_r == S_CONNECT) && pidx_r == 8'h00
      && int'(dump) + int'(conn) > int'(precon)
      |-> int'(cyc_r) == (int'(dump) + int'(conn) - int'(precon))
          * CYC_PER_US)
      else $error("first float length wrong"); // [R6]
   a_connect_len: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(state_r == S_CONNECT) && conn == 5'h02
      |-> ##99 state_r == S_CONNECT ##1 state_r != S_CONNECT)
      else $error("connect of 2 us not 100 cycles"); // [R8]
   a_fire_mask: assert property (@(posedge clk) disable iff (!rst_n)
      led_drive != 3'h0 |-> $past(fire_en) && $past(state_r) == S_FLOAT)
      else $error("led fired in masked position"); // [R14]
   a_sign_first: assert property (@(posedge clk) disable iff (!rst_n)
      state_r == S_FLOAT && pos == 2'h0 && m12 == MATH_SUB_ADD
      |=> pulse_sub && !pulse_add)
      else $error("first pulse not subtracted"); // [R17] [R18]
   a_integ_neg: assert property (@(posedge clk) disable iff (!rst_n)
      integ_negative |-> pd_connect && integ_active)
      else $error("negative phase outside charge dump"); // [R16]
   a_result_once: assert property (@(posedge clk) disable iff (!rst_n)
      last_end |-> ##2 result_valid ##1 !result_valid)
      else $error("result not written once at train end"); // [R15]
endmodule // float_led_pulse_sequencer

// ### sim/afe_model.sv
module afe_model
   import fltseq_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic [2:0]        led_drive,
   input  wire logic              pd_connect,
   output logic signed [13:0]     adc_sample
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        lit_r;
   logic        conn_q_r;
   logic [13:0] noise_r;
   // ***************
   // charge seen by the photodiode during the last float
   // ***************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lit_r    <= 1'b0;
         conn_q_r <= 1'b0;
         noise_r  <= 14'h0000;
      end else begin
         conn_q_r <= pd_connect;
         noise_r  <= noise_r + 14'h1235;
         if (led_drive != 3'h0) begin
            lit_r <= 1'b1;
         end else if (conn_q_r && !pd_connect) begin
            lit_r <= 1'b0;
         end
      end
   end
   // off the dump phase the level is meaningless, so it keeps moving
   assign adc_sample = !pd_connect ? noise_r :
                       (lit_r ? 14'h044C : 14'h0064);
endmodule // afe_model

// ### sim/testbench.sv
module testbench
   import fltseq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LIM = 6000;
   logic clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0;
   logic [8:0] awaddr = 9'h000, araddr = 9'h000;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, pd_connect, busy;
   logic integ_active, integ_negative, pulse_add, pulse_sub, result_valid;
   logic [1:0] bresp, rresp, r;
   logic [2:0] led_drive, ledv;
   logic signed [13:0] adc_sample;
   logic signed [23:0] result_data, res;
   logic [7:0] lit_pat, add_pat, sub_pat;
   logic [31:0] d;
   int bad_count = 0, n_checks = 0, np, nres, conn_cyc, led_cyc;
   int int_cyc, neg_cyc;
   logic seen, conn_q;
   always #10 clk = ~clk;
   float_led_pulse_sequencer float_led_pulse_sequencer_inst (
      .clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .adc_sample(adc_sample), .led_drive(led_drive),
      .pd_connect(pd_connect), .integ_active(integ_active),
      .integ_negative(integ_negative), .pulse_add(pulse_add),
      .pulse_sub(pulse_sub), .result_valid(result_valid),
      .result_data(result_data), .busy(busy));
   afe_model afe_model_inst (.clk(clk), .rst_n(rst_n), .led_drive(led_drive),
      .pd_connect(pd_connect), .adc_sample(adc_sample));
   // ***************
   // observe the front-end controls pulse by pulse
   // ***************
   always @(negedge clk) begin
      if (led_drive != 3'h0) begin
         seen = 1; ledv = led_drive; led_cyc++;
      end
      if (pd_connect) conn_cyc++;
      if (integ_active) int_cyc++;
      if (integ_negative) neg_cyc++;
      if (pd_connect && !conn_q) begin
         lit_pat[np] = seen; add_pat[np] = pulse_add; sub_pat[np] = pulse_sub;
         seen = 0; np++;
      end
      conn_q = pd_connect;
      if (result_valid) begin nres++; res = result_data; end
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic guard(input int n);
      if (n >= LIM) begin bad_count++; summarize(); end
   endtask
   task automatic wr(input logic [6:0] i, input logic [15:0] v,
                     input logic [1:0] e);
      int n; bit a, w, ta, tw;
      @(posedge clk);
      awaddr <= {i, 2'h0}; wdata <= {16'h0000, v}; wstrb <= 4'h3;
      awvalid <= 1; wvalid <= 1; bready <= 1; a = 0; w = 0; n = 0;
      while (!(a && w) && n < LIM) begin
         @(negedge clk); ta = !a && awready; tw = !w && wready;
         @(posedge clk); n++;
         if (ta) begin awvalid <= 0; a = 1; end
         if (tw) begin wvalid <= 0; w = 1; end
      end
      do begin @(negedge clk); r = bresp; ta = bvalid; @(posedge clk); n++;
      end while (!ta && n < LIM);
      bready <= 0; guard(n); chk(32'(r), 32'(e));
   endtask
   task automatic rd(input logic [6:0] i, output logic [31:0] v);
      int n; bit t;
      @(posedge clk); araddr <= {i, 2'h0}; arvalid <= 1; rready <= 1; n = 0;
      do begin @(negedge clk); t = arready; @(posedge clk); n++;
      end while (!t && n < LIM);
      arvalid <= 0;
      do begin @(negedge clk); v = rdata; r = rresp; t = rvalid;
         @(posedge clk); n++; end while (!t && n < LIM);
      rready <= 0; guard(n);
   endtask
   task automatic run_b(input logic [1:0] c);
      int n;
      wr(7'h3F, {c, 14'h0207}, RESP_OKAY);
      np = 0; nres = 0; conn_cyc = 0; led_cyc = 0; ledv = 0; seen = 0;
      int_cyc = 0;
      neg_cyc = 0;
      wr(7'h70, 16'h0003, RESP_OKAY);
      n = 0;
      while (nres == 0 && n < LIM) begin @(posedge clk); n++; end
      guard(n); repeat (10) @(posedge clk);
      chk(nres, 1);
      chk(np, 8);
      chk(conn_cyc, 32'h320);
      chk(ledv, c == 0 ? 3'h0 : 3'h1 << (c - 1));
      chk(lit_pat, c == 0 ? 8'h00 : 8'h66);
      chk(led_cyc, c == 0 ? 0 : 32'h190);
      chk(add_pat, 8'h66);
      chk(sub_pat, 8'h99);
      chk(32'(res), c == 0 ? 32'h0 : 32'h0FA0);
      chk(int_cyc, 32'h3E8);
      chk(neg_cyc, 32'h320);
      rd(7'h72, d);
      chk(d, c == 0 ? 32'h0 : 32'h0FA0);
      chk(32'(busy), 0);
      $display("float run with choice %0d done", c);
   endtask
   // ***************
   // main sequence
   // ***************
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1;
      rd(7'h30, d); chk(d, 32'h0);
      rd(7'h00, d); chk(d, 32'h0); chk(32'(r), 32'(RESP_SLVERR));
      wr(7'h71, 16'h00FF, RESP_SLVERR);
      wr(7'h5A, 16'h9000, RESP_OKAY);
      rd(7'h5A, d); chk(d, 32'h9000);
      $display("register test done");
      wr(7'h14, 16'h0001, RESP_OKAY);
      wr(7'h59, 16'h6600, RESP_OKAY);
      wr(7'h35, 16'h0208, RESP_OKAY);
      wr(7'h36, 16'h0804, RESP_OKAY);
      wr(7'h37, 16'h0000, RESP_OKAY);
      wr(7'h3B, 16'h1810, RESP_OKAY);
      wr(7'h58, 16'h0440, RESP_OKAY);
      for (int c = 0; c < 4; c++) run_b(2'(c));
      wr(7'h5E, 16'h6200, RESP_OKAY);
      nres = 0;
      wr(7'h70, 16'h0001, RESP_OKAY);
      repeat (20) @(posedge clk);
      rd(7'h71, d); chk(d & 32'h21, 32'h20);
      chk(nres, 0);
      $display("refused start test done");
      summarize();
   end
endmodule // testbench
